//--- design/dsld_blink_timer.v
/*
  free-running half-period timer for the lamp blink.
  assumes one clock, an active-low async reset and a clock enable.
*/
`timescale 1ns/100ps
module dsld_blink_timer #(
  parameter CNT_W      = 26,
  parameter HALF_CYCLES = 50000000
) (
  input  wire             sys_clk,
  input  wire             rst_b,
  input  wire             clk_en,
  input  wire             restart,
  output reg              phase_r
);

  localparam integer     LAST_I = HALF_CYCLES - 1;
  localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];
  // restart edge is already the first on cycle, so counting resumes at one
  localparam [CNT_W-1:0] ONE    = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] cnt_r;

  // =========================================
  // counter and phase
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= {CNT_W{1'b0}};
      phase_r <= 1'b1;
    end else if (clk_en) begin
      if (restart) begin
        cnt_r   <= ONE;
        phase_r <= 1'b1;
      end else if (cnt_r == LAST) begin
        cnt_r   <= {CNT_W{1'b0}};
        phase_r <= ~phase_r;
      end else begin
        cnt_r <= cnt_r + ONE;
      end
    end
  end

endmodule

//--- design/dsld_lamp_driver.v
/*
  drive status lamp driver: picks the lamp level from spindle state,
  command activity, format progress and the polarity select bit, and
  drives the active-low open-collector lamp pin.
  assumes all inputs synchronous to sys_clk; the pad resolves the pin
  from status_lamp_oe (driven low while oe is high, released otherwise).
*/
`timescale 1ns/100ps
`include "dsld_consts.vh"
module dsld_lamp_driver #(
  parameter BLINK_HALF_CYCLES = `DSLD_BLINK_CYCLES,
  parameter CNT_W             = 26
) (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       clk_en,
  input  wire [1:0] spindle_state,
  input  wire       cmd_active,
  input  wire       format_active,
  input  wire       cyl_change,
  input  wire       lamp_polarity_select,
  output reg        status_lamp_drive_n,
  output reg        status_lamp_oe
);

  // =========================================
  // one-hot lamp modes
  localparam [2:0] MODE_STEADY = 3'h1;
  localparam [2:0] MODE_BLINK  = 3'h2;
  localparam [2:0] MODE_FORMAT = 3'h4;

  // =========================================
  // internal state and decode
  reg  [2:0] mode_r;
  reg  [2:0] mode_nxt;
  reg        fmt_lamp_r;
  reg        fmt_lamp_nxt;
  reg        lamp_r;
  reg        lamp_nxt;
  reg        steady_lamp;
  reg        spin_down;
  reg        spin_up;
  reg        spin_moving;
  reg        entering_blink;
  reg        entering_format;
  reg        fmt_start_lamp;
  reg        fmt_flip;
  wire       blink_phase;
  wire       blink_restart;

  // =========================================
  // spindle state decode
  always @* begin
    spin_down   = 1'b0;
    spin_up     = 1'b0;
    spin_moving = 1'b0;
    case (spindle_state)
      `DSLD_SPIN_DOWN: begin
        spin_down = 1'b1;
      end
      `DSLD_SPIN_UP: begin
        spin_up = 1'b1;
      end
      `DSLD_SPIN_MOVING_A: begin
        spin_moving = 1'b1;
      end
      `DSLD_SPIN_MOVING_B: begin
        spin_moving = 1'b1;
      end
      default: begin
        spin_moving = 1'b0;
      end
    endcase
  end

  // =========================================
  // steady table
  always @* begin
    steady_lamp = `DSLD_LAMP_OFF;
    if (spin_down) begin
      if (cmd_active) begin
        steady_lamp = `DSLD_LAMP_ON;
      end else begin
        steady_lamp = `DSLD_LAMP_OFF;
      end
    end else if (spin_up) begin
      if (cmd_active) begin
        steady_lamp = lamp_polarity_select;
      end else begin
        steady_lamp = ~lamp_polarity_select;
      end
    end else begin
      steady_lamp = `DSLD_LAMP_OFF;
    end
  end

  // =========================================
  // mode selection
  always @* begin
    mode_nxt = MODE_STEADY;
    if (format_active) begin
      mode_nxt = MODE_FORMAT;
    end else if (spin_moving) begin
      mode_nxt = MODE_BLINK;
    end else begin
      mode_nxt = MODE_STEADY;
    end
  end

  always @* begin
    entering_blink  = (mode_nxt == MODE_BLINK) && (mode_r != MODE_BLINK);
    entering_format = (mode_nxt == MODE_FORMAT) && (mode_r != MODE_FORMAT);
  end

  // restart blink in its on phase when blink mode is entered
  assign blink_restart = entering_blink;

  // =========================================
  // blink timebase
  dsld_blink_timer #(
    .CNT_W       (CNT_W),
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .restart (blink_restart),
    .phase_r (blink_phase)
  );

  // =========================================
  // format toggle
  always @* begin
    fmt_flip       = format_active & cyl_change;
    fmt_start_lamp = fmt_lamp_r;
    fmt_lamp_nxt   = fmt_lamp_r;
    if (entering_format) begin
      // entering format starts from the current lamp level
      fmt_start_lamp = lamp_r;
    end
    if (mode_nxt == MODE_FORMAT) begin
      if (fmt_flip) begin
        fmt_lamp_nxt = ~fmt_start_lamp;
      end else begin
        fmt_lamp_nxt = fmt_start_lamp;
      end
    end
  end

  // =========================================
  // lamp level
  always @* begin
    lamp_nxt = steady_lamp;
    case (mode_nxt)
      MODE_FORMAT: begin
        lamp_nxt = fmt_lamp_nxt;
      end
      MODE_BLINK: begin
        // timer output lags restart by one cycle; force on meanwhile
        lamp_nxt = blink_restart ? `DSLD_LAMP_ON : blink_phase;
      end
      MODE_STEADY: begin
        lamp_nxt = steady_lamp;
      end
      default: begin
        lamp_nxt = `DSLD_LAMP_OFF;
      end
    endcase
  end

  // =========================================
  // mode register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_STEADY;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
    end
  end

  // =========================================
  // format lamp register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_lamp_r <= `DSLD_LAMP_OFF;
    end else if (clk_en) begin
      fmt_lamp_r <= fmt_lamp_nxt;
    end
  end

  // =========================================
  // internal lamp level
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lamp_r <= `DSLD_LAMP_OFF;
    end else if (clk_en) begin
      lamp_r <= lamp_nxt;
    end
  end

  // =========================================
  // pin drive
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_lamp_drive_n <= ~`DSLD_LAMP_OFF;
      status_lamp_oe      <= `DSLD_LAMP_OFF;
    end else if (clk_en) begin
      status_lamp_drive_n <= ~lamp_nxt;
      status_lamp_oe      <= lamp_nxt;
    end
  end

endmodule

//--- include/dsld_consts.vh
/*
  constants for the drive status lamp driver: spindle state codes,
  blink timing, lamp levels.
  assumes plain verilog-2005 and inclusion by bare name.
*/
`ifndef DSLD_CONSTS_VH
`define DSLD_CONSTS_VH

// spindle state codes on spindle_state
`define DSLD_SPIN_DOWN      2'h0
`define DSLD_SPIN_UP        2'h1
`define DSLD_SPIN_MOVING_A  2'h2
`define DSLD_SPIN_MOVING_B  2'h3

// blink half period, in ms, and clock rate in khz
`define DSLD_BLINK_HALF_MS  500
`define DSLD_CLK_KHZ        100000
`define DSLD_BLINK_CYCLES   (`DSLD_BLINK_HALF_MS * `DSLD_CLK_KHZ)

`define DSLD_LAMP_ON        1'b1
`define DSLD_LAMP_OFF       1'b0

`endif

//--- sim/dsld_lamp_driver_tb.sv
/* lamp driver bench; assumes the lamp model and the checker */
`timescale 1ns/100ps
module dsld_lamp_driver_tb;
  logic sys_clk = 0, rst_b = 0, clk_en = 1, cmd_active = 0, format_active = 0;
  logic cyl_change = 0, lamp_polarity_select = 0;
  logic [1:0] spindle_state = 2'h0;
  wire        status_lamp_drive_n, status_lamp_oe, lit;
  int         error_cnt = 0, check_count = 0, cyc = 0;
  dsld_lamp_driver #(.BLINK_HALF_CYCLES(4), .CNT_W(4)) dut (.*);
  dsld_led_model led (.oe(status_lamp_oe), .lit(lit));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc > 500) begin
    error_cnt++;
    finish_test;
  end
  task automatic chk(logic x);
    check_count++;
    if (lit !== x || status_lamp_drive_n !== !x) begin
      error_cnt++;
      $display("BAD %0t lamp %b pin %b", $time, lit, status_lamp_drive_n);
    end
  endtask
  task automatic go(logic [1:0] s, logic c, f, y, p);
    {spindle_state, cmd_active, format_active, cyl_change, lamp_polarity_select} = {s, c, f, y, p};
    @(negedge sys_clk);
  endtask
  task automatic t_steady;
    for (int i = 0; i < 8; i++) begin
      go({1'h0, i[2]}, i[1], 0, 0, i[0]);
      chk(i[2] ? !(i[1] ^ i[0]) : i[1]);
    end
  endtask
  task automatic t_blink;
    for (int i = 0; i < 18; i++) begin
      go({1'h1, i > 8}, 0, 0, 0, 0);
      chk(i % 8 < 4);
    end
  endtask
  task automatic t_fmt;
    logic l;
    l = lit;
    go(2'h2, 0, 1, 0, 0);
    chk(l);
    for (int i = 0; i < 4; i++) begin
      go(2'h2, 0, 1, i < 3, 0);
      l ^= i < 3;
      chk(l);
    end
    go(2'h2, 0, 0, 0, 0);
    chk(1);
    go(2'h1, 0, 0, 1, 0);
    chk(1);
  endtask
  task automatic t_hold;
    go(2'h0, 1, 0, 0, 0);
    chk(1);
    clk_en = 0;
    go(2'h0, 0, 0, 0, 0);
    chk(1);
    clk_en = 1;
    go(2'h0, 0, 0, 0, 0);
    chk(0);
  endtask
  task automatic t_reset;
    go(2'h1, 0, 0, 0, 0);
    chk(1);
    rst_b = 0;
    go(2'h1, 0, 0, 0, 0);
    chk(0);
    rst_b = 1;
    go(2'h1, 0, 0, 0, 0);
    chk(1);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_b = 1;
    chk(0);
    t_steady;
    t_blink;
    t_fmt;
    t_hold;
    t_reset;
    finish_test;
  end
endmodule
bind dsld_lamp_driver dsld_lamp_monitor #(.H(BLINK_HALF_CYCLES)) mon (.*);

//--- sim/dsld_lamp_monitor.sv
/* lamp driver port checker; assumes a bind from the bench top */
`timescale 1ns/100ps
module dsld_lamp_monitor #(parameter H = 4) (
  input wire logic sys_clk, rst_b, clk_en, cmd_active, format_active, cyl_change,
  input wire logic lamp_polarity_select, status_lamp_drive_n, status_lamp_oe,
  input wire logic [1:0] spindle_state
);
  wire       n = status_lamp_drive_n;
  wire       e = clk_en & ~format_active;
  wire [1:0] s = spindle_state;
  wire       b = e & s[1];
  logic [7:0] c_r;
  // enabled blink cycles since entry
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) c_r <= 8'h0;
    else if (clk_en) c_r <= b ? c_r + {7'h0, ~&c_r} : 8'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_end; b && c_r == 2*H-1; endsequence
  a_oe_tracks: assert property (status_lamp_oe == !n) else $error("oe");
  a_down_idle: assert property (e && s == 2'h0 && !cmd_active |=> n)
    else $error("idle");
  a_down_busy: assert property (e && s == 2'h0 && cmd_active |=> !n)
    else $error("busy");
  a_up_table: assert property (e && s == 2'h1
    |=> n == $past(cmd_active ^ lamp_polarity_select)) else $error("up");
  a_fmt_toggle: assert property (clk_en && format_active && cyl_change
    |=> n != $past(n)) else $error("toggle");
  a_fmt_hold: assert property (clk_en && format_active && !cyl_change
    |=> $stable(n)) else $error("hold");
  a_blink_start: assert property (b && c_r == 8'h0 |=> !n) else $error("start");
  a_blink_wave: assert property (s_end |=> n && !$past(n, H) && $past(n, H-1))
    else $error("wave");
endmodule

//--- sim/dsld_led_model.sv
/* external lamp with pull-up; assumes oe high sinks the pin */
`timescale 1ns/100ps
module dsld_led_model (
  input  wire logic oe,
  output wire logic lit
);
  // released pin rises to the anode supply
  wire pin = oe ? 1'h0 : 1'h1;
  assign lit = !pin;
endmodule
